// File: logic/pmd_pkg.sv
// Constants for the peripheral module disable register bank
package pmd_pkg;
    localparam int PMD_DATA_W = 16;
    localparam int PMD_ADDR_W = 4;
    // ----------------------------------------
    // Register offset and reset value
    // ----------------------------------------
    localparam logic [3:0] PMD_REG1_OFS = 4'h0;
    localparam logic [15:0] PMD_REG1_RST = 16'h0000;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int PMD_TIMER5_BIT = 15;
    localparam int PMD_TIMER4_BIT = 14;
    localparam int PMD_TIMER3_BIT = 13;
    localparam int PMD_TIMER2_BIT = 12;
    localparam int PMD_TIMER1_BIT = 11;
    localparam int PMD_TWI_BIT = 7;
    localparam int PMD_UART_BIT = 5;
    localparam int PMD_SPI_BIT = 3;
    localparam int PMD_ADC_BIT = 0;
    // Implemented bits; all others are unimplemented
    localparam logic [15:0] PMD_IMPL_MASK = 16'hF8A9;
endpackage

// File: logic/pmd_bus_if.sv
// Register write and read path shared between the bank and its store
`timescale 1ns/1ps
interface pmd_bus_if;
    import pmd_pkg::*;
    logic wrEn;
    logic [PMD_DATA_W-1:0] wrData;
    logic [PMD_DATA_W-1:0] regValue;
    modport ctrl (output wrEn, output wrData, input regValue);
    modport store (input wrEn, input wrData, output regValue);
endinterface

// File: logic/pmd_reg_store.sv
// Storage of the disable register with masked writes
`timescale 1ns/1ps
module pmd_reg_store
    import pmd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    pmd_bus_if.store bus
);
    logic [PMD_DATA_W-1:0] store_q;
    logic [PMD_DATA_W-1:0] store_d;

    // Masking on write keeps unimplemented bits at zero forever
    assign store_d = bus.wrEn ? (bus.wrData & PMD_IMPL_MASK) : store_q;
    assign bus.regValue = store_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            store_q <= PMD_REG1_RST;
        end else begin
            store_q <= store_d;
        end
    end
endmodule

// File: logic/pmd_top.sv
// Peripheral module disable register bank, top level
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module pmd_top
    import pmd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [PMD_ADDR_W-1:0] regAddr,
    input wire logic [PMD_DATA_W-1:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [PMD_DATA_W-1:0] regRdData,
    output logic timerFiveOff,
    output logic timerFourOff,
    output logic timerThreeOff,
    output logic timerTwoOff,
    output logic timerOneOff,
    output logic twoWireUnitOff,
    output logic serialPortOff,
    output logic serialPeriphOff,
    output logic converterOff
);
    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    pmd_bus_if bus ();
    logic [PMD_DATA_W-1:0] regRdData_q;
    logic [PMD_DATA_W-1:0] regRdData_d;
    logic [PMD_DATA_W-1:0] offBits_q;
    wire hitReg = (regAddr == PMD_REG1_OFS);
    wire writeHit = regWrite && hitReg;
    wire readHit = regRead && hitReg;
    // Unmapped addresses read as zero and swallow writes
    assign bus.wrEn = regWrite & hitReg;
    assign bus.wrData = regWrData;
    assign regRdData_d = (regRead && hitReg) ? bus.regValue : 16'h0000;

    pmd_reg_store u_store (
        .clk(clk),
        .rst(rst),
        .bus(bus)
    );

    // ----------------------------------------
    // Output flops
    // ----------------------------------------
    // Disable lines follow the store one cycle later so every output is a flop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdData_q <= PMD_REG1_RST;
            offBits_q <= PMD_REG1_RST;
        end else begin
            regRdData_q <= regRdData_d;
            offBits_q <= bus.regValue;
        end
    end

    assign regRdData = regRdData_q;
    assign timerFiveOff = offBits_q[PMD_TIMER5_BIT];
    assign timerFourOff = offBits_q[PMD_TIMER4_BIT];
    assign timerThreeOff = offBits_q[PMD_TIMER3_BIT];
    assign timerTwoOff = offBits_q[PMD_TIMER2_BIT];
    assign timerOneOff = offBits_q[PMD_TIMER1_BIT];
    assign twoWireUnitOff = offBits_q[PMD_TWI_BIT];
    assign serialPortOff = offBits_q[PMD_UART_BIT];
    assign serialPeriphOff = offBits_q[PMD_SPI_BIT];
    assign converterOff = offBits_q[PMD_ADC_BIT];

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_write_hit;
        regWrite && hitReg;
    endsequence

    a_timer_five_follow: assert property (@(posedge clk) disable iff (rst)
        s_write_hit |-> ##2 (timerFiveOff == $past(regWrData[PMD_TIMER5_BIT], 2)))
        else $error("timer five disable does not follow write");
    a_timer_four_follow: assert property (@(posedge clk) disable iff (rst)
        s_write_hit |-> ##2 (timerFourOff == $past(regWrData[PMD_TIMER4_BIT], 2)))
        else $error("timer four disable does not follow write");
    a_timer_three_follow: assert property (@(posedge clk) disable iff (rst)
        s_write_hit |-> ##2 (timerThreeOff == $past(regWrData[PMD_TIMER3_BIT], 2)))
        else $error("timer three disable does not follow write");
    a_timer_two_follow: assert property (@(posedge clk) disable iff (rst)
        s_write_hit |-> ##2 (timerTwoOff == $past(regWrData[PMD_TIMER2_BIT], 2)))
        else $error("timer two disable does not follow write");
    a_timer_one_follow: assert property (@(posedge clk) disable iff (rst)
        s_write_hit |-> ##2 (timerOneOff == $past(regWrData[PMD_TIMER1_BIT], 2)))
        else $error("timer one disable does not follow write");
    a_two_wire_follow: assert property (@(posedge clk) disable iff (rst)
        s_write_hit |-> ##2 (twoWireUnitOff == $past(regWrData[PMD_TWI_BIT], 2)))
        else $error("two-wire disable does not follow write");
    a_serial_port_follow: assert property (@(posedge clk) disable iff (rst)
        s_write_hit |-> ##2 (serialPortOff == $past(regWrData[PMD_UART_BIT], 2)))
        else $error("serial port disable does not follow write");
    a_unimpl_read_zero: assert property (@(posedge clk) disable iff (rst)
        regRead |=> ((regRdData & ~PMD_IMPL_MASK) == 16'h0000))
        else $error("unimplemented bit read as one");
    a_read_back_value: assert property (@(posedge clk) disable iff (rst)
        s_write_hit ##1 (regRead && hitReg && !regWrite)
        |=> (regRdData == ($past(regWrData, 2) & PMD_IMPL_MASK)))
        else $error("read back differs from written value");
    a_spi_adc_follow: assert property (@(posedge clk) disable iff (rst)
        s_write_hit |-> ##2 (serialPeriphOff == $past(regWrData[PMD_SPI_BIT], 2)
            && converterOff == $past(regWrData[PMD_ADC_BIT], 2)))
        else $error("spi or converter disable does not follow write");

    // ----------------------------------------
    // Hold checks
    // ----------------------------------------
    // A line may move only two edges after a write that hits the register
    a_timer_five_hold: assert property (@(posedge clk) disable iff (rst)
        !writeHit |-> ##2 $stable(timerFiveOff))
        else $error("timer five disable moved without a write");
    a_timer_four_hold: assert property (@(posedge clk) disable iff (rst)
        !writeHit |-> ##2 $stable(timerFourOff))
        else $error("timer four disable moved without a write");
    a_timer_three_hold: assert property (@(posedge clk) disable iff (rst)
        !writeHit |-> ##2 $stable(timerThreeOff))
        else $error("timer three disable moved without a write");
    a_timer_two_hold: assert property (@(posedge clk) disable iff (rst)
        !writeHit |-> ##2 $stable(timerTwoOff))
        else $error("timer two disable moved without a write");
    a_timer_one_hold: assert property (@(posedge clk) disable iff (rst)
        !writeHit |-> ##2 $stable(timerOneOff))
        else $error("timer one disable moved without a write");
    a_two_wire_hold: assert property (@(posedge clk) disable iff (rst)
        !writeHit |-> ##2 $stable(twoWireUnitOff))
        else $error("two-wire disable moved without a write");
    a_serial_port_hold: assert property (@(posedge clk) disable iff (rst)
        !writeHit |-> ##2 $stable(serialPortOff))
        else $error("serial port disable moved without a write");
    a_serial_periph_hold: assert property (@(posedge clk) disable iff (rst)
        !writeHit |-> ##2 $stable(serialPeriphOff))
        else $error("spi disable moved without a write");
    a_converter_hold: assert property (@(posedge clk) disable iff (rst)
        !writeHit |-> ##2 $stable(converterOff))
        else $error("converter disable moved without a write");

    // ----------------------------------------
    // Read-back checks per field
    // ----------------------------------------
    sequence s_read_hit;
        regRead && hitReg && !regWrite;
    endsequence

    a_timer_five_read: assert property (@(posedge clk) disable iff (rst)
        s_write_hit ##1 s_read_hit
        |=> (regRdData[PMD_TIMER5_BIT] == $past(regWrData[PMD_TIMER5_BIT], 2)))
        else $error("timer five bit reads back wrong");
    a_timer_four_read: assert property (@(posedge clk) disable iff (rst)
        s_write_hit ##1 s_read_hit
        |=> (regRdData[PMD_TIMER4_BIT] == $past(regWrData[PMD_TIMER4_BIT], 2)))
        else $error("timer four bit reads back wrong");
    a_timer_three_read: assert property (@(posedge clk) disable iff (rst)
        s_write_hit ##1 s_read_hit
        |=> (regRdData[PMD_TIMER3_BIT] == $past(regWrData[PMD_TIMER3_BIT], 2)))
        else $error("timer three bit reads back wrong");
    a_timer_two_read: assert property (@(posedge clk) disable iff (rst)
        s_write_hit ##1 s_read_hit
        |=> (regRdData[PMD_TIMER2_BIT] == $past(regWrData[PMD_TIMER2_BIT], 2)))
        else $error("timer two bit reads back wrong");
    a_timer_one_read: assert property (@(posedge clk) disable iff (rst)
        s_write_hit ##1 s_read_hit
        |=> (regRdData[PMD_TIMER1_BIT] == $past(regWrData[PMD_TIMER1_BIT], 2)))
        else $error("timer one bit reads back wrong");
    a_two_wire_read: assert property (@(posedge clk) disable iff (rst)
        s_write_hit ##1 s_read_hit
        |=> (regRdData[PMD_TWI_BIT] == $past(regWrData[PMD_TWI_BIT], 2)))
        else $error("two-wire bit reads back wrong");
    a_serial_port_read: assert property (@(posedge clk) disable iff (rst)
        s_write_hit ##1 s_read_hit
        |=> (regRdData[PMD_UART_BIT] == $past(regWrData[PMD_UART_BIT], 2)))
        else $error("serial port bit reads back wrong");
    a_serial_periph_read: assert property (@(posedge clk) disable iff (rst)
        s_write_hit ##1 s_read_hit
        |=> (regRdData[PMD_SPI_BIT] == $past(regWrData[PMD_SPI_BIT], 2)))
        else $error("spi bit reads back wrong");
    a_converter_read: assert property (@(posedge clk) disable iff (rst)
        s_write_hit ##1 s_read_hit
        |=> (regRdData[PMD_ADC_BIT] == $past(regWrData[PMD_ADC_BIT], 2)))
        else $error("converter bit reads back wrong");

    // ----------------------------------------
    // Reset checks
    // ----------------------------------------
    // Two sampled edges of reset, so the flops have seen it before they are judged
    sequence s_reset_held;
        rst ##1 rst;
    endsequence

    a_timer_five_clear: assert property (@(posedge clk)
        s_reset_held |-> !timerFiveOff)
        else $error("timer five disable not cleared by reset");
    a_timer_four_clear: assert property (@(posedge clk)
        s_reset_held |-> !timerFourOff)
        else $error("timer four disable not cleared by reset");
    a_timer_three_clear: assert property (@(posedge clk)
        s_reset_held |-> !timerThreeOff)
        else $error("timer three disable not cleared by reset");
    a_timer_two_clear: assert property (@(posedge clk)
        s_reset_held |-> !timerTwoOff)
        else $error("timer two disable not cleared by reset");
    a_timer_one_clear: assert property (@(posedge clk)
        s_reset_held |-> !timerOneOff)
        else $error("timer one disable not cleared by reset");
    a_two_wire_clear: assert property (@(posedge clk)
        s_reset_held |-> !twoWireUnitOff)
        else $error("two-wire disable not cleared by reset");
    a_serial_port_clear: assert property (@(posedge clk)
        s_reset_held |-> !serialPortOff)
        else $error("serial port disable not cleared by reset");
    a_serial_periph_clear: assert property (@(posedge clk)
        s_reset_held |-> !serialPeriphOff)
        else $error("spi disable not cleared by reset");
    a_converter_clear: assert property (@(posedge clk)
        s_reset_held |-> !converterOff)
        else $error("converter disable not cleared by reset");
    a_read_data_clear: assert property (@(posedge clk)
        s_reset_held |-> (regRdData == 16'h0000))
        else $error("read data not cleared by reset");

    // ----------------------------------------
    // Read path and store checks
    // ----------------------------------------
    a_read_idle_zero: assert property (@(posedge clk) disable iff (rst)
        !readHit |=> (regRdData == 16'h0000))
        else $error("read data not zero outside a mapped read");
    a_store_masked: assert property (@(posedge clk) disable iff (rst)
        ((bus.regValue & ~PMD_IMPL_MASK) == 16'h0000))
        else $error("unimplemented bit held in the register");
    a_stray_write: assert property (@(posedge clk) disable iff (rst)
        regWrite && !hitReg |=> $stable(bus.regValue))
        else $error("write to an unmapped address changed the register");
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the peripheral module disable register bank
`timescale 1ns/1ps
module tb_top;
    import pmd_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [PMD_ADDR_W-1:0] regAddr = 4'h0;
    logic [PMD_DATA_W-1:0] regWrData = 16'h0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [PMD_DATA_W-1:0] regRdData;
    wire [8:0] offs;
    int mismatches = 0;
    int comparisons = 0;
    always #25 clk = ~clk;
    pmd_top dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .timerFiveOff(offs[8]), .timerFourOff(offs[7]), .timerThreeOff(offs[6]),
        .timerTwoOff(offs[5]), .timerOneOff(offs[4]), .twoWireUnitOff(offs[3]),
        .serialPortOff(offs[2]), .serialPeriphOff(offs[1]), .converterOff(offs[0]));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] pick(input logic [15:0] d);
        return {7'h00, d[15], d[14], d[13], d[12], d[11], d[7], d[5], d[3], d[0]};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Callers enter just after an edge, so strobes stay one cycle long
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        chk(regRdData, exp);
        @(posedge clk);
    endtask
    task automatic end_sim;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({7'h00, offs}, 16'h0000);
        rd(4'h0, 16'h0000);
        // Walking one also shows that no bit leaks into a neighbouring output
        for (int i = 0; i < 16; i++) begin
            wr(4'h0, 16'h0001 << i);
            rd(4'h0, (16'h0001 << i) & 16'hF8A9);
            chk({7'h00, offs}, pick(16'h0001 << i));
        end
        wr(4'h0, 16'hFFFF);
        rd(4'h0, 16'hF8A9);
        chk({7'h00, offs}, 16'h01FF);
        wr(4'h5, 16'h0000);
        rd(4'h5, 16'h0000);
        rd(4'h0, 16'hF8A9);
        wr(4'h0, 16'h0000);
        rd(4'h0, 16'h0000);
        chk({7'h00, offs}, 16'h0000);
        // Second reset in mid-run, taken with every line high, must clear everything again
        wr(4'h0, 16'hFFFF);
        rd(4'h0, 16'hF8A9);
        chk({7'h00, offs}, 16'h01FF);
        rst <= 1'b1;
        @(posedge clk);
        #1;
        chk({7'h00, offs}, 16'h0000);
        chk(regRdData, 16'h0000);
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(4'h0, 16'h0000);
        end_sim;
    end
endmodule
